//--- hw/cisr_defs.svh
/*
 * Constants for the cache identity and virtual identity register bank:
 * access encodings, field positions, fixed field values and reset values.
 * Assumes it is included by bare name from the bank module.
 */
`ifndef CISR_DEFS_SVH
`define CISR_DEFS_SVH

// ==========================================================================
// Access encodings (opcode1, CRn, CRm, opcode2)
// ==========================================================================
`define CISR_CRN_ID 4'h0
`define CISR_CRM_ID 4'h0
`define CISR_CRN_CTL 4'h1
`define CISR_CRM_CTL 4'h0
`define CISR_OP1_HIER 3'h1
`define CISR_OP2_HIER 3'h1
`define CISR_OP1_AUX 3'h1
`define CISR_OP2_AUX 3'h7
`define CISR_OP1_SIZE 3'h1
`define CISR_OP2_SIZE 3'h0
`define CISR_OP1_SEL 3'h2
`define CISR_OP2_SEL 3'h0
`define CISR_OP1_VIRT 3'h4
`define CISR_OP2_VPID 3'h0
`define CISR_OP2_VAFF 3'h5
`define CISR_OP1_MAIN 3'h0
`define CISR_OP2_MAIN 3'h0
`define CISR_OP2_AFF 3'h5
`define CISR_OP1_CTL 3'h0
`define CISR_OP2_CTL 3'h0

// ==========================================================================
// Hierarchy descriptor fields
// ==========================================================================
`define CISR_UU_LEVEL 3'h1
`define CISR_COH_LEVEL 3'h2
`define CISR_IS_LEVEL 3'h1
`define CISR_NO_CACHE 3'h0
`define CISR_L2_TYPE 3'h4
`define CISR_L1_TYPE 3'h3

// ==========================================================================
// Selector fields, size descriptor values and reset values
// ==========================================================================
`define CISR_SEL_LVL_HI 3
`define CISR_SEL_LVL_LO 1
`define CISR_SEL_IND 0
`define CISR_SEL_MASK 32'h0000_000F
`define CISR_LVL1 3'h0
`define CISR_LVL2 3'h1
`define CISR_SIZE_L1D 32'h701F_E00A
`define CISR_SIZE_L1I 32'h201F_E00A
`define CISR_SIZE_L2 32'h707F_E07A
`define CISR_SEL_RESET 32'h0000_0000
`define CISR_VIRT_RESET 32'h0000_0000
`define CISR_CTL_RESET 32'h0000_0000

`endif

//--- hw/cisr_pkg.sv
/*
 * Types for the cache identity and virtual identity register bank.
 * Assumes the constants header sits beside it.
 */
package cisr_pkg;
   // =======================================================================
   // Processor modes as seen by the bank
   // =======================================================================
   typedef enum logic [2:0] {
      CISR_MODE_USER = 3'h0,
      CISR_MODE_PRIV = 3'h1,
      CISR_MODE_MON = 3'h2,
      CISR_MODE_HYP = 3'h3
   } cisr_mode_e;
endpackage

//--- hw/cisr_bank.sv
/*
 * Register bank for cache hierarchy and size identity, the size selector,
 * the virtual identity overrides and the banked system control register.
 * Assumes the pipeline presents one access at a time with a one-cycle
 * valid strobe, on the core clock, and keeps the mode and security inputs
 * steady during it.
 */
`timescale 1ns/100ps
`default_nettype none
`include "cisr_defs.svh"

// Behaviour
// - Hierarchy uniprocessor unification level reads one
// - Hierarchy coherency level reads two
// - Hierarchy inner shareable unification reads one
// - Levels three to seven report no cache
// - Level two type reports unified
// - Level one type reports split caches
// - Hierarchy read at opcode1 1, opcode2 1
// - Auxiliary identity reads zero, ignores writes
// - Selector banked per security state
// - Selector level field bits three to one
// - Selector bit zero picks instruction cache
// - Selector chooses size descriptor value
// - Selector at opcode1 2, opcode2 0
// - Hierarchy and selector need privilege one
// - Nonsecure main identity reads virtual value outside hypervisor and monitor modes
// - Nonsecure affinity reads virtual value outside hypervisor and monitor modes
// - Virtual identities only hypervisor or monitor nonsecure
// - Virtual identities at opcode1 4, opcode2 0/5
// - Control register banked, read and write
// - Control register needs privilege one
// - Write lock blocks secure control writes
// - Hierarchy read only and shared
module cisr_bank #(
   parameter logic [31:0] MAIN_ID = 32'h0000_0000,
   parameter logic [31:0] AFFINITY = 32'h0000_0000
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   // Access request from the pipeline
   input wire logic acc_valid_i,
   input wire logic acc_write_i,
   input wire logic [2:0] acc_op1_i,
   input wire logic [3:0] acc_crn_i,
   input wire logic [3:0] acc_crm_i,
   input wire logic [2:0] acc_op2_i,
   input wire logic [31:0] acc_wdata_i,
   // Processor state
   input wire cisr_pkg::cisr_mode_e mode_i,
   input wire logic nonsecure_state_bit_i,
   input wire logic secure_sysreg_write_lock_i,
   // Answer
   output logic acc_done_o,
   output logic acc_undef_o,
   output logic [31:0] acc_rdata_o,
   // Current control register copy for the rest of the core
   output logic [31:0] system_control_o
);

   // MAIN_ID and AFFINITY defaults are arbitrary, neutral values.
   if ($bits(MAIN_ID) != 32 || $bits(AFFINITY) != 32) begin : g_id_width
      $error("cisr_bank: identity width must be 32");
   end

   // ========================================================================
   // Decode
   // ========================================================================
   logic is_priv;
   logic is_hyp;
   logic is_mon_ns;
   logic id_grp;
   logic ctl_grp;
   logic hit_hier;
   logic hit_aux;
   logic hit_size;
   logic hit_sel;
   logic hit_vpid;
   logic hit_vaff;
   logic hit_main;
   logic hit_aff;
   logic hit_ctl;
   logic virt_ok;
   logic ns_view;
   logic lock_fault;
   logic acc_fault;
   logic wr_ok;

   assign is_priv = (mode_i != cisr_pkg::CISR_MODE_USER);
   assign is_hyp = (mode_i == cisr_pkg::CISR_MODE_HYP);
   assign is_mon_ns = (mode_i == cisr_pkg::CISR_MODE_MON) &&
      nonsecure_state_bit_i;
   // Accesses in monitor mode always work on the secure copies.
   assign ns_view = nonsecure_state_bit_i &&
      (mode_i != cisr_pkg::CISR_MODE_MON);
   assign id_grp = (acc_crn_i == `CISR_CRN_ID) && (acc_crm_i == `CISR_CRM_ID);
   assign ctl_grp = (acc_crn_i == `CISR_CRN_CTL) &&
      (acc_crm_i == `CISR_CRM_CTL);
   assign hit_hier = id_grp && (acc_op1_i == `CISR_OP1_HIER) &&
      (acc_op2_i == `CISR_OP2_HIER);
   assign hit_aux = id_grp && (acc_op1_i == `CISR_OP1_AUX) &&
      (acc_op2_i == `CISR_OP2_AUX);
   assign hit_size = id_grp && (acc_op1_i == `CISR_OP1_SIZE) &&
      (acc_op2_i == `CISR_OP2_SIZE);
   assign hit_sel = id_grp && (acc_op1_i == `CISR_OP1_SEL) &&
      (acc_op2_i == `CISR_OP2_SEL);
   assign hit_vpid = id_grp && (acc_op1_i == `CISR_OP1_VIRT) &&
      (acc_op2_i == `CISR_OP2_VPID);
   assign hit_vaff = id_grp && (acc_op1_i == `CISR_OP1_VIRT) &&
      (acc_op2_i == `CISR_OP2_VAFF);
   assign hit_main = id_grp && (acc_op1_i == `CISR_OP1_MAIN) &&
      (acc_op2_i == `CISR_OP2_MAIN);
   assign hit_aff = id_grp && (acc_op1_i == `CISR_OP1_MAIN) &&
      (acc_op2_i == `CISR_OP2_AFF);
   assign hit_ctl = ctl_grp && (acc_op1_i == `CISR_OP1_CTL) &&
      (acc_op2_i == `CISR_OP2_CTL);
   assign virt_ok = is_hyp || is_mon_ns;
   assign lock_fault = hit_ctl && acc_write_i && !ns_view &&
      secure_sysreg_write_lock_i;
   // hierarchy, size, main identity and affinity registers refuse writes
   assign acc_fault = acc_valid_i && (
      (!is_priv && (hit_hier || hit_aux || hit_size || hit_sel ||
         hit_main || hit_aff || hit_ctl)) ||
      ((hit_vpid || hit_vaff) && !virt_ok) ||
      (acc_write_i && (hit_hier || hit_size || hit_main || hit_aff)) ||
      lock_fault);
   assign wr_ok = acc_valid_i && acc_write_i && !acc_fault;

   // ========================================================================
   // Storage
   // ========================================================================
   logic [31:0] sel_s_reg;
   logic [31:0] sel_ns_reg;
   logic [31:0] vpid_reg;
   logic [31:0] vaff_reg;
   logic [31:0] ctl_s_reg;
   logic [31:0] ctl_ns_reg;

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sel_s_reg <= `CISR_SEL_RESET;
         sel_ns_reg <= `CISR_SEL_RESET;
      end else if (wr_ok && hit_sel) begin
         if (ns_view) begin
            sel_ns_reg <= acc_wdata_i & `CISR_SEL_MASK;
         end else begin
            sel_s_reg <= acc_wdata_i & `CISR_SEL_MASK;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         vpid_reg <= `CISR_VIRT_RESET;
         vaff_reg <= `CISR_VIRT_RESET;
      end else if (wr_ok) begin
         if (hit_vpid) begin
            vpid_reg <= acc_wdata_i;
         end
         if (hit_vaff) begin
            vaff_reg <= acc_wdata_i;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctl_s_reg <= `CISR_CTL_RESET;
         ctl_ns_reg <= `CISR_CTL_RESET;
      end else if (wr_ok && hit_ctl) begin
         if (ns_view) begin
            ctl_ns_reg <= acc_wdata_i;
         end else begin
            ctl_s_reg <= acc_wdata_i;
         end
      end
   end

   // ========================================================================
   // Read data
   // ========================================================================
   logic [31:0] hier_val;
   logic [31:0] sel_cur;
   logic [31:0] size_val;
   logic [31:0] rd_next;

   // fixed hierarchy fields, top bits zero
   assign hier_val = {2'b00, `CISR_UU_LEVEL, `CISR_COH_LEVEL, `CISR_IS_LEVEL,
      `CISR_NO_CACHE, `CISR_NO_CACHE, `CISR_NO_CACHE, `CISR_NO_CACHE,
      `CISR_NO_CACHE, `CISR_L2_TYPE, `CISR_L1_TYPE};
   assign sel_cur = ns_view ? sel_ns_reg : sel_s_reg;

   always_comb begin
      size_val = 32'h0000_0000;
      case (sel_cur[`CISR_SEL_LVL_HI:`CISR_SEL_LVL_LO])
         `CISR_LVL1: begin
            size_val = sel_cur[`CISR_SEL_IND] ? `CISR_SIZE_L1I :
               `CISR_SIZE_L1D;
         end
         `CISR_LVL2: begin
            // There is no level two instruction cache to describe.
            size_val = sel_cur[`CISR_SEL_IND] ? 32'h0000_0000 :
               `CISR_SIZE_L2;
         end
         default: begin
            size_val = 32'h0000_0000;
         end
      endcase
   end

   always_comb begin
      rd_next = 32'h0000_0000;
      if (hit_hier) begin
         rd_next = hier_val;
      end else if (hit_size) begin
         rd_next = size_val;
      end else if (hit_sel) begin
         rd_next = sel_cur;
      end else if (hit_vpid) begin
         rd_next = vpid_reg;
      end else if (hit_vaff) begin
         rd_next = vaff_reg;
      end else if (hit_main) begin
         rd_next = (ns_view && !is_hyp) ? vpid_reg : MAIN_ID;
      end else if (hit_aff) begin
         rd_next = (ns_view && !is_hyp) ? vaff_reg : AFFINITY;
      end else if (hit_ctl) begin
         rd_next = ns_view ? ctl_ns_reg : ctl_s_reg;
      end else if (hit_aux) begin
         rd_next = 32'h0000_0000;
      end
   end

   // ========================================================================
   // Answer
   // ========================================================================
   // Faulted and write accesses return zero data so no state leaks out.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         acc_done_o <= 1'b0;
         acc_undef_o <= 1'b0;
         acc_rdata_o <= 32'h0000_0000;
      end else begin
         acc_done_o <= acc_valid_i;
         acc_undef_o <= acc_fault;
         acc_rdata_o <= (acc_valid_i && !acc_write_i && !acc_fault) ?
            rd_next : 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         system_control_o <= `CISR_CTL_RESET;
      end else begin
         system_control_o <= nonsecure_state_bit_i ? ctl_ns_reg : ctl_s_reg;
      end
   end

   // ========================================================================
   // Assertions
   // ========================================================================
   sequence s_read_req(logic hit);
      acc_valid_i && !acc_write_i && hit && is_priv;
   endsequence

   property p_hier_value;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      s_read_req(hit_hier) |=> acc_rdata_o == 32'h0A20_0023;
   endproperty
   a_hier_value: assert property (p_hier_value)
      else $error("hierarchy value wrong");

   property p_user_fault;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      acc_valid_i && !is_priv && (hit_hier || hit_sel || hit_ctl)
         |=> acc_undef_o && acc_done_o;
   endproperty
   a_user_fault: assert property (p_user_fault)
      else $error("user access not faulted");

   property p_sel_held;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      acc_fault |=> $stable(sel_s_reg) && $stable(sel_ns_reg) &&
         $stable(ctl_s_reg) && $stable(vpid_reg) &&
         $stable(ctl_ns_reg) && $stable(vaff_reg);
   endproperty
   a_sel_held: assert property (p_sel_held)
      else $error("faulted access changed state");

   property p_lock;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      acc_valid_i && acc_write_i && hit_ctl && !ns_view &&
         secure_sysreg_write_lock_i |=> acc_undef_o && $stable(ctl_s_reg);
   endproperty
   a_lock: assert property (p_lock)
      else $error("locked secure control write went through");

   property p_virt_main;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      s_read_req(hit_main && ns_view && !is_hyp)
         |=> acc_rdata_o == $past(vpid_reg);
   endproperty
   a_virt_main: assert property (p_virt_main)
      else $error("nonsecure main identity not virtual");

   property p_virt_aff;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      s_read_req(hit_aff && ns_view && !is_hyp)
         |=> acc_rdata_o == $past(vaff_reg);
   endproperty
   a_virt_aff: assert property (p_virt_aff)
      else $error("nonsecure affinity not virtual");

   property p_virt_priv;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      acc_valid_i && (hit_vpid || hit_vaff) && !is_hyp && !is_mon_ns
         |=> acc_undef_o;
   endproperty
   a_virt_priv: assert property (p_virt_priv)
      else $error("virtual identity reached from wrong mode");

   property p_sel_reserved;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      sel_s_reg[31:4] == 28'h000_0000 && sel_ns_reg[31:4] == 28'h000_0000;
   endproperty
   a_sel_reserved: assert property (p_sel_reserved)
      else $error("selector reserved bits set");

   property p_aux_zero;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      acc_valid_i && hit_aux |=> acc_rdata_o == 32'h0000_0000;
   endproperty
   a_aux_zero: assert property (p_aux_zero)
      else $error("auxiliary identity not zero");

   property p_size_l1i;
      @(posedge core_clk_i) disable iff (!reset_n_i)
      s_read_req(hit_size && sel_cur[3:0] == 4'h1)
         |=> acc_rdata_o == 32'h201F_E00A;
   endproperty
   a_size_l1i: assert property (p_size_l1i)
      else $error("size value not from selector");

endmodule
`default_nettype wire

//--- dv/cisr_pipe_model.sv
/*
 * Pipeline model that issues one register access at a time to the bank.
 * Assumes the bank answers exactly one clock edge after it takes valid.
 */
`timescale 1ns/100ps
`default_nettype none
module cisr_pipe_model (
   // Clock
   input wire logic clk_i,
   // Access request
   output logic valid_o,
   output logic write_o,
   output logic [2:0] op1_o,
   output logic [3:0] crn_o,
   output logic [3:0] crm_o,
   output logic [2:0] op2_o,
   output logic [31:0] wdata_o,
   output var cisr_pkg::cisr_mode_e mode_o,
   output logic ns_o,
   output logic lock_o,
   // Answer
   input wire logic done_i,
   input wire logic undef_i,
   input wire logic [31:0] rdata_i
);
   initial begin
      valid_o = 1'b0;
      write_o = 1'b0;
      {op1_o, crn_o, crm_o, op2_o} = 14'h0000;
      wdata_o = 32'h0000_0000;
      mode_o = cisr_pkg::CISR_MODE_USER;
      ns_o = 1'b0;
      lock_o = 1'b0;
   end

   // ========================================================================
   // One access: strobe for one edge, answer taken one edge later
   // ========================================================================
   task automatic access(input logic wr, input logic [13:0] enc,
         input logic [31:0] wd, input cisr_pkg::cisr_mode_e md,
         input logic ns, input logic lk, output logic dn,
         output logic ud, output logic [31:0] rd);
      @(posedge clk_i);
      valid_o <= 1'b1;
      write_o <= wr;
      {op1_o, crn_o, crm_o, op2_o} <= enc;
      wdata_o <= wd;
      mode_o <= md;
      ns_o <= ns;
      lock_o <= lk;
      @(posedge clk_i);
      valid_o <= 1'b0;
      // Released data must not keep showing the last value.
      wdata_o <= ~wd;
      #1;
      dn = done_i;
      ud = undef_i;
      rd = rdata_i;
   endtask
endmodule
`default_nettype wire

//--- dv/tb.sv
/*
 * Self-checking bench for the cache and virtual identity register bank.
 * Assumes the bank package is compiled first and the pipeline model beside.
 */
`timescale 1ns/100ps
`default_nettype none
module tb;
   // ========================================================================
   // Encodings {opcode1, CRn, CRm, opcode2} and modes
   // ========================================================================
   localparam logic [13:0] E_HIER = {3'h1, 8'h00, 3'h1};
   localparam logic [13:0] E_AUX = {3'h1, 8'h00, 3'h7};
   localparam logic [13:0] E_SIZE = {3'h1, 8'h00, 3'h0};
   localparam logic [13:0] E_SEL = {3'h2, 8'h00, 3'h0};
   localparam logic [13:0] E_VPID = {3'h4, 8'h00, 3'h0};
   localparam logic [13:0] E_VAFF = {3'h4, 8'h00, 3'h5};
   localparam logic [13:0] E_MAIN = {3'h0, 8'h00, 3'h0};
   localparam logic [13:0] E_AFF = {3'h0, 8'h00, 3'h5};
   localparam logic [13:0] E_CTL = {3'h0, 8'h10, 3'h0};
   // Identity values are arbitrary.
   localparam logic [31:0] MID = 32'h1234_5678;
   localparam logic [31:0] AFF = 32'h0000_0102;
   localparam cisr_pkg::cisr_mode_e USR = cisr_pkg::CISR_MODE_USER;
   localparam cisr_pkg::cisr_mode_e PRV = cisr_pkg::CISR_MODE_PRIV;
   localparam cisr_pkg::cisr_mode_e MON = cisr_pkg::CISR_MODE_MON;
   localparam cisr_pkg::cisr_mode_e HYP = cisr_pkg::CISR_MODE_HYP;

   logic core_clk_i, reset_n_i, valid, write, ns, lock, done, undef;
   logic [2:0] op1, op2;
   logic [3:0] crn, crm;
   logic [31:0] wdata, rdata, sys_ctl, rd, seed, a, b, vp, va;
   cisr_pkg::cisr_mode_e mode;
   int error_cnt, total_checks, cyc;

   cisr_bank #(.MAIN_ID(MID), .AFFINITY(AFF)) DUT (
      .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .acc_valid_i(valid),
      .acc_write_i(write), .acc_op1_i(op1), .acc_crn_i(crn),
      .acc_crm_i(crm), .acc_op2_i(op2), .acc_wdata_i(wdata),
      .mode_i(mode), .nonsecure_state_bit_i(ns),
      .secure_sysreg_write_lock_i(lock), .acc_done_o(done),
      .acc_undef_o(undef), .acc_rdata_o(rdata), .system_control_o(sys_ctl));

   cisr_pipe_model u_pipe (
      .clk_i(core_clk_i), .valid_o(valid), .write_o(write), .op1_o(op1),
      .crn_o(crn), .crm_o(crm), .op2_o(op2), .wdata_o(wdata),
      .mode_o(mode), .ns_o(ns), .lock_o(lock), .done_i(done),
      .undef_i(undef), .rdata_i(rdata));

   initial begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end

   // ========================================================================
   // Expectations and helpers
   // ========================================================================
   function automatic logic [31:0] hier_exp();
      return {2'b00, 3'b001, 3'b010, 3'b001, 15'h0000, 3'b100, 3'b011};
   endfunction

   function automatic logic [31:0] size_exp(input logic [3:0] s);
      case (s)
         4'h0: return 32'h701F_E00A;
         4'h1: return 32'h201F_E00A;
         4'h2: return 32'h707F_E07A;
         default: return 32'h0000_0000;
      endcase
   endfunction

   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic acc(input int wr, input logic [13:0] enc,
         input logic [31:0] wd, input cisr_pkg::cisr_mode_e md,
         input int n, input int lk, input int eu);
      logic dn, ud;
      u_pipe.access(wr[0], enc, wd, md, n[0], lk[0], dn, ud, rd);
      check({31'h0, dn}, 32'h1);
      check({31'h0, ud}, {31'h0, eu[0]});
      if (eu[0]) begin
         check(rd, 32'h0);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         end_of_test();
      end
   end

   // ========================================================================
   // Main sequence
   // ========================================================================
   initial begin
      reset_n_i = 1'b0;
      error_cnt = 0;
      total_checks = 0;
      cyc = 0;
      seed = 32'h0000_D1D0;
      repeat (10) @(posedge core_clk_i);
      check({done, undef, rdata[29:0]} | sys_ctl, 32'h0);
      reset_n_i <= 1'b1;
      acc(0, E_SEL, 0, PRV, 0, 0, 0); check(rd, 32'h0);
      acc(0, E_HIER, 0, PRV, 0, 0, 0); check(rd, hier_exp());
      acc(0, E_HIER, 0, PRV, 1, 0, 0); check(rd, hier_exp());
      acc(1, E_HIER, rnd(), PRV, 0, 0, 1);
      acc(0, E_HIER, 0, USR, 0, 0, 1);
      acc(1, E_AUX, rnd(), PRV, 0, 0, 0);
      acc(0, E_AUX, 0, PRV, 0, 0, 0); check(rd, 32'h0);
      acc(1, E_SIZE, rnd(), PRV, 0, 0, 1);
      acc(1, E_AFF, rnd(), PRV, 1, 0, 1);
      $display("test hierarchy and auxiliary done");
      for (int i = 0; i < 16; i++) begin
         a = (rnd() & 32'hFFFF_FFF0) | {28'h000_0000, i[3:0]};
         b = (rnd() & 32'hFFFF_FFF0) | {28'h000_0000, 4'hF - i[3:0]};
         acc(1, E_SEL, a, PRV, 0, 0, 0);
         acc(1, E_SEL, b, PRV, 1, 0, 0);
         acc(0, E_SEL, 0, PRV, 0, 0, 0); check(rd, a & 32'hF);
         acc(0, E_SIZE, 0, PRV, 0, 0, 0); check(rd, size_exp(a[3:0]));
         acc(0, E_SEL, 0, PRV, 1, 0, 0); check(rd, b & 32'hF);
         acc(0, E_SIZE, 0, PRV, 1, 0, 0); check(rd, size_exp(b[3:0]));
      end
      acc(1, E_SEL, 32'h1, USR, 0, 0, 1);
      acc(0, E_SEL, 0, PRV, 0, 0, 0); check(rd, 32'hF);
      $display("test selector done");
      vp = rnd();
      va = rnd();
      acc(1, E_VPID, rnd(), HYP, 1, 0, 0);
      acc(1, E_VAFF, va, HYP, 1, 0, 0);
      acc(1, E_VPID, vp, MON, 1, 0, 0);
      acc(1, E_VPID, rnd(), MON, 0, 0, 1);
      acc(1, E_VAFF, rnd(), PRV, 1, 0, 1);
      acc(0, E_VPID, 0, HYP, 1, 0, 0); check(rd, vp);
      acc(0, E_VAFF, 0, MON, 1, 0, 0); check(rd, va);
      acc(0, E_MAIN, 0, PRV, 1, 0, 0); check(rd, vp);
      acc(0, E_AFF, 0, PRV, 1, 0, 0); check(rd, va);
      acc(0, E_MAIN, 0, PRV, 0, 0, 0); check(rd, MID);
      acc(0, E_AFF, 0, HYP, 1, 0, 0); check(rd, AFF);
      $display("test virtual identity done");
      a = rnd();
      b = rnd();
      acc(1, E_CTL, a, PRV, 0, 0, 0);
      acc(1, E_CTL, b, PRV, 1, 0, 0);
      acc(0, E_CTL, 0, PRV, 0, 0, 0); check(rd, a);
      check(sys_ctl, a);
      acc(0, E_CTL, 0, PRV, 1, 0, 0); check(rd, b);
      check(sys_ctl, b);
      acc(1, E_CTL, rnd(), USR, 1, 0, 1);
      acc(1, E_CTL, rnd(), PRV, 0, 1, 1);
      acc(1, E_CTL, rnd(), MON, 1, 1, 1);
      acc(0, E_CTL, 0, PRV, 0, 1, 0); check(rd, a);
      acc(1, E_CTL, ~b, PRV, 1, 1, 0);
      acc(0, E_CTL, 0, PRV, 1, 0, 0); check(rd, ~b);
      $display("test control register done");
      end_of_test();
   end
endmodule
`default_nettype wire
